/* File: alarm_cfg_pkg.sv */
package alarm_cfg_pkg;
  // Register offsets on the device register port.
  localparam logic [7:0] ADDR_ROUTE_EN = 8'h12;
  localparam logic [7:0] ADDR_THRESH = 8'h13;
  localparam logic [7:0] ADDR_DELAY = 8'h14;
  localparam logic [7:0] ADDR_BAL_LOW = 8'h15;
  localparam logic [7:0] ADDR_BAL_TOP = 8'h16;
  // Bit positions in the routing and enable register.
  localparam int BIT_SPLIT = 15;
  localparam int BIT_EN_SC = 3;
  localparam int BIT_DISCHARGE_OVERCURRENT_ENABLE = 2;
  localparam int BIT_CHARGE_OVERCURRENT_ENABLE = 1;
  localparam int BIT_CURRENT_PROTECTION_ENABLE = 0;
  // Five-bit field positions shared by thresholds and delays.
  localparam int FLD_SC_LSB = 10;
  localparam int FLD_OCD_LSB = 5;
  localparam int FLD_OCC_LSB = 0;
  localparam int FLD_W = 5;
  // Field reset codes.
  localparam logic [4:0] THR_RST = 5'h01;
  localparam logic [4:0] DLY_SC_RST = 5'h01;
  localparam logic [4:0] DLY_OC_RST = 5'h00;
  // Threshold steps in millivolts and the charge saturation point.
  localparam logic [9:0] STEP_SC_MV = 10'h014;
  localparam logic [9:0] STEP_OCD_MV = 10'h00A;
  localparam logic [9:0] STEP_OCC_MV = 10'h005;
  localparam logic [4:0] OCC_SAT_CODE = 5'h17;
  localparam logic [9:0] OCC_SAT_MV = 10'h078;
  // Threshold outputs after reset, matching the reset codes.
  localparam logic [9:0] SC_MV_RST = 10'h028;
  localparam logic [9:0] OCD_MV_RST = 10'h014;
  localparam logic [9:0] OCC_MV_RST = 10'h00A;
  // Width of the top balance register that is kept.
  localparam int BAL_TOP_W = 6;
  // Timing: clock period and delay units.
  localparam int CLK_PERIOD_NS = 40;
  localparam int SC_UNIT_NS = 31250;
  localparam int OC_UNIT_MS = 10;
  localparam int NS_PER_MS = 1000000;
  // Least times round up to whole cycles.
  localparam logic [23:0] SC_UNIT_CYC =
    24'((SC_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [23:0] OC_UNIT_CYC =
    24'((OC_UNIT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CNT_W = 24;
endpackage : alarm_cfg_pkg

/* File: alarm_host_model.sv */
`timescale 1ns/1ps
module alarm_host_model (
  // Clock shared with the device.
  input wire logic clk_in,
  // Register port driven by the host.
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [15:0] reg_wdata_out,
  // Read data returned by the device.
  input wire logic [15:0] reg_rdata_in
);
  // Idle port: strobes low, address and data parked on a non-zero pattern.
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'hFF;
    reg_wdata_out = 16'hFFFF;
  end

  // One-cycle write strobe; data is inverted after release so stale values never look valid.
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    logic [15:0] word;
    word = data;
    if (addr == 8'h16) begin
      word = data & 16'h0001;
    end
    @(posedge clk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= addr;
    reg_wdata_out <= word;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~addr;
    reg_wdata_out <= ~word;
  endtask : write_reg

  // One-cycle read strobe; the answer is registered at the sampling edge.
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
    @(posedge clk_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= addr;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~addr;
    #1;
    data = reg_rdata_in;
  endtask : read_reg
endmodule : alarm_host_model

/* File: current_alarm_and_balance_cfg.sv */
`timescale 1ns/1ps
// Behaviour
// - Split set: primary shows short circuit only.
// - Split clear: primary shows every alarm together.
// - Bit 3 enables short circuit detection.
// - Bit 2 enables discharge overcurrent detection.
// - Bit 1 enables charge overcurrent detection.
// - Bit 0 enables overall current protection.
// - Short circuit threshold is (code+1)*20 mV.
// - Discharge threshold is (code+1)*10 mV.
// - Charge threshold (code+1)*5 mV, saturates 120.
// - Short circuit delay is code*31.25 us.
// - Discharge delay is (code+1)*10 ms.
// - Charge delay is (code+1)*10 ms.
// - Alarm only if trip persists past delay.
// - Seventeen select bits balance cells one-seventeen.
module current_alarm_and_balance_cfg #(
  // Cycles in one 10 ms overcurrent delay step.
  parameter logic [23:0] OC_UNIT_CYC = alarm_cfg_pkg::OC_UNIT_CYC
) (
  // Clock and reset.
  input wire logic CLK_SYS_IN,
  input wire logic ARST_N_IN,
  // Register port from the serial transport.
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  output logic [15:0] REG_RDATA_OUT,
  // Comparator trips and voltage alarms from the analog side.
  input wire logic SC_TRIP_IN,
  input wire logic OCD_TRIP_IN,
  input wire logic OCC_TRIP_IN,
  input wire logic OV_ALARM_IN,
  input wire logic UV_ALARM_IN,
  // Alarm outputs.
  output logic PRIMARY_ALARM_OUT,
  output logic SECONDARY_ALARM_OUT,
  // Threshold settings in millivolts for the comparators.
  output logic [9:0] SC_THRESH_MV_OUT,
  output logic [9:0] OCD_THRESH_MV_OUT,
  output logic [9:0] OCC_THRESH_MV_OUT,
  // Balance enables, bit 0 is cell one.
  output logic [16:0] CELL_BALANCE_EN_OUT
);

  // All block state in one record.
  typedef struct packed {
    logic split;                  // Alarm routing split.
    logic [3:0] en;               // Enables, sc/ocd/occ/cp.
    logic [14:0] thr;             // Three threshold codes.
    logic [14:0] dly;             // Three delay codes.
    logic [15:0] bal_low;         // Cells one to sixteen.
    logic [5:0] bal_top;          // Cell seventeen plus spare bits.
    logic [15:0] rdata;           // Read answer.
    logic [4:0] sync1;            // First synchroniser stage.
    logic [4:0] sync2;            // Second synchroniser stage.
    logic [23:0] cnt_sc;          // Short circuit qualify count.
    logic [23:0] cnt_ocd;         // Discharge qualify count.
    logic [23:0] cnt_occ;         // Charge qualify count.
    logic alm_sc;                 // Qualified short circuit.
    logic alm_ocd;                // Qualified discharge overcurrent.
    logic alm_occ;                // Qualified charge overcurrent.
    logic prim;                   // Primary alarm pin.
    logic sec;                    // Secondary alarm pin.
    logic [9:0] sc_mv;            // Short circuit threshold.
    logic [9:0] ocd_mv;           // Discharge threshold.
    logic [9:0] occ_mv;           // Charge threshold.
    logic [16:0] bal;             // Balance enables.
  } state_t;

  state_t st_reg;
  state_t st_next;

  // Decoded views of the current state.
  logic [4:0] c_thr_sc;
  logic [4:0] c_thr_ocd;
  logic [4:0] c_thr_occ;
  logic [4:0] c_dly_sc;
  logic [4:0] c_dly_ocd;
  logic [4:0] c_dly_occ;
  logic armed_sc;
  logic armed_ocd;
  logic armed_occ;
  logic [23:0] tgt_sc;
  logic [23:0] tgt_ocd;
  logic [23:0] tgt_occ;

  // One detector step: count while armed and tripped, alarm at target.
  // The count stops at the target, so it cannot wrap while held.
  function automatic logic [24:0] qualify(input logic armed,
      input logic trip, input logic [23:0] cnt, input logic [23:0] tgt);
    logic [24:0] r;
    r = 25'h0000000;
    if (armed && trip) begin
      if (cnt >= tgt) begin
        r = {1'b1, cnt};
      end else begin
        r = {1'b0, cnt + 24'h000001};
      end
    end
    return r;
  endfunction : qualify

  // Field slices of the threshold and delay registers.
  assign c_thr_sc = st_reg.thr[alarm_cfg_pkg::FLD_SC_LSB +: alarm_cfg_pkg::FLD_W];
  assign c_thr_ocd = st_reg.thr[alarm_cfg_pkg::FLD_OCD_LSB +: alarm_cfg_pkg::FLD_W];
  assign c_thr_occ = st_reg.thr[alarm_cfg_pkg::FLD_OCC_LSB +: alarm_cfg_pkg::FLD_W];
  assign c_dly_sc = st_reg.dly[alarm_cfg_pkg::FLD_SC_LSB +: alarm_cfg_pkg::FLD_W];
  assign c_dly_ocd = st_reg.dly[alarm_cfg_pkg::FLD_OCD_LSB +: alarm_cfg_pkg::FLD_W];
  assign c_dly_occ = st_reg.dly[alarm_cfg_pkg::FLD_OCC_LSB +: alarm_cfg_pkg::FLD_W];

  assign armed_sc = st_reg.en[alarm_cfg_pkg::BIT_EN_SC] &&
    st_reg.en[alarm_cfg_pkg::BIT_CURRENT_PROTECTION_ENABLE];
  assign armed_ocd = st_reg.en[alarm_cfg_pkg::BIT_DISCHARGE_OVERCURRENT_ENABLE] &&
    st_reg.en[alarm_cfg_pkg::BIT_CURRENT_PROTECTION_ENABLE];
  assign armed_occ = st_reg.en[alarm_cfg_pkg::BIT_CHARGE_OVERCURRENT_ENABLE] &&
    st_reg.en[alarm_cfg_pkg::BIT_CURRENT_PROTECTION_ENABLE];

  assign tgt_sc = 24'({19'h00000, c_dly_sc} * alarm_cfg_pkg::SC_UNIT_CYC);
  assign tgt_ocd = 24'(({19'h00000, c_dly_ocd} + 24'h000001) * OC_UNIT_CYC);
  assign tgt_occ = 24'(({19'h00000, c_dly_occ} + 24'h000001) * OC_UNIT_CYC);

  // Next-state logic for registers, detectors and outputs.
  always_comb begin
    logic [24:0] q_sc;
    logic [24:0] q_ocd;
    logic [24:0] q_occ;
    logic volt;
    st_next = st_reg;
    q_sc = qualify(armed_sc, st_reg.sync2[0], st_reg.cnt_sc, tgt_sc);
    q_ocd = qualify(armed_ocd, st_reg.sync2[1], st_reg.cnt_ocd, tgt_ocd);
    q_occ = qualify(armed_occ, st_reg.sync2[2], st_reg.cnt_occ, tgt_occ);
    volt = st_reg.sync2[3] | st_reg.sync2[4];
    // Trip inputs come from the analog side and are synchronised.
    st_next.sync1 = {UV_ALARM_IN, OV_ALARM_IN, OCC_TRIP_IN, OCD_TRIP_IN, SC_TRIP_IN};
    st_next.sync2 = st_reg.sync1;
    // Register writes; reserved bits other than the bal_top spare bits are not stored.
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        alarm_cfg_pkg::ADDR_ROUTE_EN: begin
          st_next.split = REG_WDATA_IN[alarm_cfg_pkg::BIT_SPLIT];
          st_next.en = REG_WDATA_IN[3:0];
        end
        alarm_cfg_pkg::ADDR_THRESH: begin
          st_next.thr = REG_WDATA_IN[14:0];
        end
        alarm_cfg_pkg::ADDR_DELAY: begin
          st_next.dly = REG_WDATA_IN[14:0];
        end
        alarm_cfg_pkg::ADDR_BAL_LOW: begin
          st_next.bal_low = REG_WDATA_IN;
        end
        alarm_cfg_pkg::ADDR_BAL_TOP: begin
          st_next.bal_top = REG_WDATA_IN[alarm_cfg_pkg::BAL_TOP_W-1:0];
        end
        default: begin
          // Unmapped writes are ignored.
        end
      endcase
    end
    // Read answer is captured on the read strobe; unmapped reads zero.
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        alarm_cfg_pkg::ADDR_ROUTE_EN: begin
          st_next.rdata = {st_reg.split, 11'h000, st_reg.en};
        end
        alarm_cfg_pkg::ADDR_THRESH: begin
          st_next.rdata = {1'b0, st_reg.thr};
        end
        alarm_cfg_pkg::ADDR_DELAY: begin
          st_next.rdata = {1'b0, st_reg.dly};
        end
        alarm_cfg_pkg::ADDR_BAL_LOW: begin
          st_next.rdata = st_reg.bal_low;
        end
        alarm_cfg_pkg::ADDR_BAL_TOP: begin
          st_next.rdata = {10'h000, st_reg.bal_top};
        end
        default: begin
          st_next.rdata = 16'h0000;
        end
      endcase
    end
    st_next.alm_sc = q_sc[24];
    st_next.cnt_sc = q_sc[23:0];
    st_next.alm_ocd = q_ocd[24];
    st_next.cnt_ocd = q_ocd[23:0];
    st_next.alm_occ = q_occ[24];
    st_next.cnt_occ = q_occ[23:0];
    // Pin routing; the secondary pin carries voltage and overcurrent alarms only while split is set.
    if (st_reg.split) begin
      st_next.prim = st_reg.alm_sc;
      st_next.sec = volt | st_reg.alm_ocd | st_reg.alm_occ;
    end else begin
      st_next.prim = volt | st_reg.alm_sc | st_reg.alm_ocd | st_reg.alm_occ;
      st_next.sec = 1'b0;
    end
    st_next.sc_mv = 10'({5'h00, c_thr_sc} + 10'h001) * alarm_cfg_pkg::STEP_SC_MV;
    st_next.ocd_mv = 10'({5'h00, c_thr_ocd} + 10'h001) * alarm_cfg_pkg::STEP_OCD_MV;
    if (c_thr_occ >= alarm_cfg_pkg::OCC_SAT_CODE) begin
      st_next.occ_mv = alarm_cfg_pkg::OCC_SAT_MV;
    end else begin
      st_next.occ_mv = 10'({5'h00, c_thr_occ} + 10'h001) * alarm_cfg_pkg::STEP_OCC_MV;
    end
    st_next.bal = {st_reg.bal_top[0], st_reg.bal_low};
  end

  // State register; reset sets every field to its documented default.
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_reg <= '0;
      st_reg.thr <= {alarm_cfg_pkg::THR_RST, alarm_cfg_pkg::THR_RST,
                     alarm_cfg_pkg::THR_RST};
      st_reg.dly <= {alarm_cfg_pkg::DLY_SC_RST, alarm_cfg_pkg::DLY_OC_RST,
                     alarm_cfg_pkg::DLY_OC_RST};
      st_reg.sc_mv <= alarm_cfg_pkg::SC_MV_RST;
      st_reg.ocd_mv <= alarm_cfg_pkg::OCD_MV_RST;
      st_reg.occ_mv <= alarm_cfg_pkg::OCC_MV_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register.
  assign REG_RDATA_OUT = st_reg.rdata;
  assign PRIMARY_ALARM_OUT = st_reg.prim;
  assign SECONDARY_ALARM_OUT = st_reg.sec;
  assign SC_THRESH_MV_OUT = st_reg.sc_mv;
  assign OCD_THRESH_MV_OUT = st_reg.ocd_mv;
  assign OCC_THRESH_MV_OUT = st_reg.occ_mv;
  assign CELL_BALANCE_EN_OUT = st_reg.bal;

  // Checks on the routing, arming and qualification behaviour.
  default clocking cb_sys @(posedge CLK_SYS_IN); endclocking
  default disable iff (!ARST_N_IN);

  // Split routing: primary follows the short circuit alarm alone.
  property p_split_primary;
    st_reg.split |=> PRIMARY_ALARM_OUT == $past(st_reg.alm_sc);
  endproperty
  a_split_primary: assert property (p_split_primary)
    else $error("Primary alarm wrong with split routing.");

  // Combined routing: an overcurrent alarm reaches primary, secondary stays low.
  property p_combined;
    !st_reg.split && (st_reg.alm_ocd || st_reg.alm_occ) |=>
      PRIMARY_ALARM_OUT && !SECONDARY_ALARM_OUT;
  endproperty
  a_combined: assert property (p_combined)
    else $error("Combined routing did not raise primary alarm.");

  // A disabled short circuit detector never alarms.
  property p_sc_off;
    !st_reg.en[alarm_cfg_pkg::BIT_EN_SC] |=> !st_reg.alm_sc;
  endproperty
  a_sc_off: assert property (p_sc_off)
    else $error("Short circuit alarm while disabled.");

  // A disabled discharge detector never alarms.
  property p_ocd_off;
    !st_reg.en[alarm_cfg_pkg::BIT_DISCHARGE_OVERCURRENT_ENABLE] |=> !st_reg.alm_ocd;
  endproperty
  a_ocd_off: assert property (p_ocd_off)
    else $error("Discharge alarm while disabled.");

  // A disabled charge detector never alarms.
  property p_occ_off;
    !st_reg.en[alarm_cfg_pkg::BIT_CHARGE_OVERCURRENT_ENABLE] |=> !st_reg.alm_occ;
  endproperty
  a_occ_off: assert property (p_occ_off)
    else $error("Charge alarm while disabled.");

  // Global disable clears every alarm and the discharge count.
  property p_cp_off;
    !st_reg.en[alarm_cfg_pkg::BIT_CURRENT_PROTECTION_ENABLE] |=>
      !(st_reg.alm_sc | st_reg.alm_ocd | st_reg.alm_occ) && st_reg.cnt_ocd == 24'h000000;
  endproperty
  a_cp_off: assert property (p_cp_off)
    else $error("Alarm or count active with protection disabled.");

  // Threshold outputs follow the codes.
  property p_sc_mv;
    ##1 SC_THRESH_MV_OUT == 10'(({5'h00, $past(c_thr_sc)} + 10'h001) * 10'h014);
  endproperty
  a_sc_mv: assert property (p_sc_mv)
    else $error("Short circuit threshold value wrong.");

  property p_ocd_mv;
    ##1 OCD_THRESH_MV_OUT == 10'(({5'h00, $past(c_thr_ocd)} + 10'h001) * 10'h00A);
  endproperty
  a_ocd_mv: assert property (p_ocd_mv)
    else $error("Discharge threshold value wrong.");

  property p_occ_sat;
    c_thr_occ >= 5'h17 |=> OCC_THRESH_MV_OUT == 10'h078;
  endproperty
  a_occ_sat: assert property (p_occ_sat)
    else $error("Charge threshold not saturated.");

  // Zero delay: a held armed trip alarms within two cycles.
  sequence s_sc_hold;
    armed_sc && c_dly_sc == 5'h00 && st_reg.sync2[0];
  endsequence
  property p_sc_zero;
    s_sc_hold ##1 s_sc_hold |-> st_reg.alm_sc;
  endproperty
  a_sc_zero: assert property (p_sc_zero)
    else $error("Zero delay short circuit alarm late.");

  // An alarm only rises once the count reached the full target.
  property p_ocd_rise;
    $rose(st_reg.alm_ocd) |-> $past(st_reg.cnt_ocd) >= $past(tgt_ocd);
  endproperty
  a_ocd_rise: assert property (p_ocd_rise)
    else $error("Discharge alarm before its delay.");

  property p_occ_rise;
    $rose(st_reg.alm_occ) |-> $past(st_reg.cnt_occ) >= $past(tgt_occ);
  endproperty
  a_occ_rise: assert property (p_occ_rise)
    else $error("Charge alarm before its delay.");

  // A trip that clears drops count and alarm on the next edge.
  property p_trip_gone;
    !st_reg.sync2[0] |=> st_reg.cnt_sc == 24'h000000 && !st_reg.alm_sc;
  endproperty
  a_trip_gone: assert property (p_trip_gone)
    else $error("Short circuit held without trip.");

  // Balance enables mirror the select registers.
  property p_balance;
    ##1 CELL_BALANCE_EN_OUT == {$past(st_reg.bal_top[0]), $past(st_reg.bal_low)};
  endproperty
  a_balance: assert property (p_balance)
    else $error("Balance enables do not match selects.");

endmodule : current_alarm_and_balance_cfg

/* File: current_alarm_and_balance_cfg_tb_top.sv */
`timescale 1ns/1ps
module current_alarm_and_balance_cfg_tb_top;
  // Short delay step keeps the overcurrent waits brief.
  localparam logic [23:0] UNIT = 24'h000014;
  logic clk_sys, arst_n, sc_trip, ocd_trip, occ_trip, ov_alarm, uv_alarm;
  logic reg_wr, reg_rd, prim, sec;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [9:0] sc_mv, ocd_mv, occ_mv;
  logic [16:0] bal;
  int bad_count = 0;
  int comparisons = 0;

  current_alarm_and_balance_cfg #(.OC_UNIT_CYC(UNIT)) current_alarm_and_balance_cfg_inst (
    .CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
    .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_RDATA_OUT(reg_rdata),
    .SC_TRIP_IN(sc_trip), .OCD_TRIP_IN(ocd_trip), .OCC_TRIP_IN(occ_trip),
    .OV_ALARM_IN(ov_alarm), .UV_ALARM_IN(uv_alarm), .PRIMARY_ALARM_OUT(prim),
    .SECONDARY_ALARM_OUT(sec), .SC_THRESH_MV_OUT(sc_mv), .OCD_THRESH_MV_OUT(ocd_mv),
    .OCC_THRESH_MV_OUT(occ_mv), .CELL_BALANCE_EN_OUT(bal));

  alarm_host_model alarm_host_model_inst (.clk_in(clk_sys), .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
    .reg_rdata_in(reg_rdata));

  // Free-running 25 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // Value compare with case equality so unknowns never match.
  task automatic check_val(input logic [16:0] got, input logic [16:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    alarm_host_model_inst.write_reg(a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    alarm_host_model_inst.read_reg(a, d);
    check_val({1'b0, d}, {1'b0, exp}, what);
  endtask : rd_chk

  // Timing compare: cycles until the chosen alarm rises must fall in lo..hi.
  task automatic wait_alarm(input bit use_sec, input int lo, input int hi, input string what);
    int n;
    n = 0;
    while (((use_sec ? sec : prim) !== 1'b1) && n <= hi) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    comparisons++;
    if (n < lo || n > hi) begin
      bad_count++;
      $display("MISMATCH at %0t: %s rose after %0d cycles", $time, what, n);
      if (n > hi) begin
        summarize();
      end
    end
  endtask : wait_alarm

  // Both alarm outputs must stay low for n cycles once the pipeline has emptied.
  // Sync, alarm and pin stages need four edges to clear; three pass before the first sample.
  task automatic stay_low(input int n, input string what);
    logic seen;
    seen = 1'b0;
    repeat (3) @(posedge clk_sys);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      seen = seen | prim | sec;
    end
    check_val({16'h0000, seen}, 17'h00000, what);
  endtask : stay_low

  task automatic test_reset();
    check_val({16'h0000, prim | sec}, 17'h00000, "alarms idle");
    check_val({7'h00, sc_mv}, 17'h00028, "sc threshold");
    check_val({7'h00, ocd_mv}, 17'h00014, "ocd threshold");
    check_val({7'h00, occ_mv}, 17'h0000A, "occ threshold");
    check_val(bal, 17'h00000, "balance idle");
    rd_chk(8'h12, 16'h0000, "route reset");
    rd_chk(8'h13, 16'h0421, "thresh reset");
    rd_chk(8'h14, 16'h0400, "delay reset");
    rd_chk(8'h15, 16'h0000, "bal low reset");
    rd_chk(8'h16, 16'h0000, "bal top reset");
    rd_chk(8'h20, 16'h0000, "unmapped read");
    $display("test_reset done");
  endtask : test_reset

  task automatic test_regs();
    wr(8'h12, 16'hFFFF);
    rd_chk(8'h12, 16'h800F, "route bits");
    wr(8'h15, 16'hA5A5);
    wr(8'h16, 16'h003F);
    rd_chk(8'h16, 16'h0001, "bal top");
    check_val(bal, 17'h1A5A5, "balance a");
    wr(8'h15, 16'h5A5A);
    wr(8'h16, 16'h0000);
    rd_chk(8'h15, 16'h5A5A, "bal low");
    check_val(bal, 17'h05A5A, "balance b");
    $display("test_regs done");
  endtask : test_regs

  task automatic test_thresh();
    logic [4:0] codes[5] = '{5'h00, 5'h01, 5'h16, 5'h17, 5'h1F};
    int k;
    foreach (codes[i]) begin
      k = codes[i];
      wr(8'h13, {1'b0, codes[i], codes[i], codes[i]});
      repeat (2) @(posedge clk_sys);
      #1;
      check_val({7'h00, sc_mv}, 17'(k * 20 + 20), "sc mv");
      check_val({7'h00, ocd_mv}, 17'(k * 10 + 10), "ocd mv");
      check_val({7'h00, occ_mv}, 17'(k >= 23 ? 120 : k * 5 + 5), "occ mv");
    end
    $display("test_thresh done");
  endtask : test_thresh

  task automatic test_route();
    wr(8'h12, 16'h0000);
    ov_alarm <= 1'b1;
    wait_alarm(1'b0, 2, 5, "ov on primary");
    check_val({16'h0000, sec}, 17'h00000, "sec quiet");
    @(posedge clk_sys);
    ov_alarm <= 1'b0;
    wr(8'h12, 16'h8000);
    stay_low(4, "ov cleared");
    @(posedge clk_sys);
    uv_alarm <= 1'b1;
    wait_alarm(1'b1, 2, 5, "uv on secondary");
    check_val({16'h0000, prim}, 17'h00000, "primary quiet");
    @(posedge clk_sys);
    uv_alarm <= 1'b0;
    stay_low(5, "uv cleared");
    $display("test_route done");
  endtask : test_route

  task automatic test_sc();
    wr(8'h14, 16'h0000);
    wr(8'h12, 16'h8009);
    sc_trip <= 1'b1;
    wait_alarm(1'b0, 2, 6, "sc no delay");
    check_val({16'h0000, sec}, 17'h00000, "sc not secondary");
    @(posedge clk_sys);
    sc_trip <= 1'b0;
    wr(8'h14, 16'h0400);
    stay_low(4, "sc cleared");
    @(posedge clk_sys);
    sc_trip <= 1'b1;
    wait_alarm(1'b0, 781, 790, "sc one step");
    @(posedge clk_sys);
    sc_trip <= 1'b0;
    stay_low(5, "sc dropped");
    @(posedge clk_sys);
    sc_trip <= 1'b1;
    repeat (300) @(posedge clk_sys);
    sc_trip <= 1'b0;
    stay_low(800, "sc short pulse");
    wr(8'h12, 16'h8008);
    sc_trip <= 1'b1;
    stay_low(900, "sc no global");
    wr(8'h12, 16'h8001);
    stay_low(900, "sc no own");
    @(posedge clk_sys);
    sc_trip <= 1'b0;
    $display("test_sc done");
  endtask : test_sc

  task automatic test_oc();
    wr(8'h14, 16'h0040);
    wr(8'h12, 16'h0005);
    ocd_trip <= 1'b1;
    wait_alarm(1'b0, 60, 66, "ocd three steps");
    check_val({16'h0000, sec}, 17'h00000, "ocd not secondary");
    @(posedge clk_sys);
    ocd_trip <= 1'b0;
    wr(8'h12, 16'h8005);
    occ_trip <= 1'b1;
    stay_low(100, "occ disabled");
    wr(8'h12, 16'h8003);
    wait_alarm(1'b1, 20, 26, "occ one step");
    check_val({16'h0000, prim}, 17'h00000, "occ not primary");
    @(posedge clk_sys);
    occ_trip <= 1'b0;
    wr(8'h12, 16'h8004);
    ocd_trip <= 1'b1;
    stay_low(100, "ocd no global");
    @(posedge clk_sys);
    ocd_trip <= 1'b0;
    $display("test_oc done");
  endtask : test_oc

  // A reset in mid-run must bring the sc and occ thresholds, balance outputs and the route, delay and low balance registers back to defaults.
  task automatic test_mid_reset();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check_val({7'h00, sc_mv}, 17'h00028, "sc mid reset");
    check_val({7'h00, occ_mv}, 17'h0000A, "occ mid reset");
    check_val(bal, 17'h00000, "balance mid reset");
    @(posedge clk_sys);
    arst_n <= 1'b1;
    rd_chk(8'h12, 16'h0000, "route mid reset");
    rd_chk(8'h14, 16'h0400, "delay mid reset");
    rd_chk(8'h15, 16'h0000, "bal low mid reset");
    $display("test_mid_reset done");
  endtask : test_mid_reset

  // Cuts a hang short at 20000 cycles, well past the length of a normal run.
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("MISMATCH at %0t: run did not finish", $time);
    summarize();
  end

  // Main sequence: reset for ten cycles, then every scenario in turn.
  initial begin
    arst_n = 1'b0;
    sc_trip = 1'b0;
    ocd_trip = 1'b0;
    occ_trip = 1'b0;
    ov_alarm = 1'b0;
    uv_alarm = 1'b0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    test_reset();
    test_regs();
    test_thresh();
    test_route();
    test_sc();
    test_oc();
    test_mid_reset();
    summarize();
  end
endmodule : current_alarm_and_balance_cfg_tb_top
